// ===== rtl/pfta_defs.svh
// Purpose: constants of the program flash table access unit
// Assumes: core clock of 250 MHz
// Notes: register select codes index the unit's special function registers
`ifndef PFTA_DEFS_SVH
`define PFTA_DEFS_SVH
// register select codes on sfr_sel
`define PFTA_SEL_CTRL 3'h0
`define PFTA_SEL_KEY 3'h1
`define PFTA_SEL_LATCH 3'h2
`define PFTA_SEL_PTRL 3'h3
`define PFTA_SEL_PTRH 3'h4
`define PFTA_SEL_PTRU 3'h5
// control register bit positions
`define PFTA_B_PGD 7
`define PFTA_B_CFG 6
`define PFTA_B_FREE 4
`define PFTA_B_ERR 3
`define PFTA_B_WRITE_ENABLE_BIT 2
`define PFTA_B_WR 1
`define PFTA_B_RD 0
// pointer update modes on tbl_mode
`define PFTA_PM_KEEP 2'h0
`define PFTA_PM_POSTINC 2'h1
`define PFTA_PM_POSTDEC 2'h2
`define PFTA_PM_PREINC 2'h3
// unlock keys and holding register reset value
`define PFTA_KEY1 8'h55
`define PFTA_KEY2 8'hAA
`define PFTA_HOLD_RST 8'hFF
// programming timer
`define PFTA_PROG_TIME_NS 2000000
`define PFTA_CLK_NS 4
`define PFTA_PROG_CYCLES (`PFTA_PROG_TIME_NS / `PFTA_CLK_NS)
`endif

// ===== rtl/pfta_pkg.sv
// Purpose: types of the program flash table access unit
// Assumes: nothing beyond the constants header
// Notes: all state of each module is one packed struct
package pfta_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_TREAD, ST_TIMED} pfta_state_e;
  typedef enum logic [1:0] {TGT_EEPROM, TGT_PROGRAM, TGT_CONFIG} pfta_target_e;
  typedef struct packed {
    logic pgd;
    logic cfg;
    logic free;
    logic err;
    logic write_enable_bit;
    logic wr;
    logic rd;
    logic [7:0] latch;
    logic [21:0] ptr;
    logic [1:0] unlock;
    pfta_state_e st;
    logic [19:0] tmr;
    logic [7:0] rdata;
    logic [21:0] faddr;
    pfta_target_e tgt;
    logic stall;
    logic prog;
    logic erase;
    logic ee_rd;
    logic done;
  } pfta_top_s;
  typedef struct packed {
    logic [7:0][7:0] bytes;
  } pfta_hold_s;
endpackage : pfta_pkg

// ===== rtl/pfta_holding.sv
// Purpose: eight byte-wide write holding registers
// Assumes: one table write at most per cycle
// Notes: a refill to all ones wins over a write in the same cycle
`timescale 1ns/10ps
`include "pfta_defs.svh"
module pfta_holding (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // table write side
  input wire logic we,
  input wire logic [2:0] idx,
  input wire logic [7:0] wdata,
  // refill after a timed write
  input wire logic refill,
  // block contents, byte 0 in the low bits
  output logic [63:0] block
);
  pfta_pkg::pfta_hold_s q;
  pfta_pkg::pfta_hold_s next_q;
  logic [7:0][7:0] next_byte;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_byte
      // all ones leaves the flash byte untouched
      assign next_byte[gi] = refill ? `PFTA_HOLD_RST :
        ((we && idx == 3'(gi)) ? wdata : q.bytes[gi]); // [RULE23] [RULE5]
    end
  endgenerate

  always_comb
  begin
    next_q = q;
    next_q.bytes = next_byte;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q <= {8{`PFTA_HOLD_RST}}; // [RULE23]
    else
      q <= next_q;
  end

  assign block = q.bytes;

  chk_hold_refill: assert property (@(posedge mclk) disable iff (!rstn) // [RULE23]
    refill |=> block == {8{`PFTA_HOLD_RST}}) else $error("holding not refilled");
endmodule : pfta_holding

// ===== rtl/pfta_top.sv
// Purpose: table read/write, erase and self-timed write control for program flash
// Assumes: core issues table requests and register accesses synchronous to mclk
// Notes: register read data is registered, one cycle behind sfr_sel
`timescale 1ns/10ps
`include "pfta_defs.svh"
// Notes on behaviour
// RULE1: reads move one byte; programming is only whole aligned 8-byte blocks
// RULE2: self erase clears one aligned 64-byte block; no bulk erase
// RULE3: fetches stall during write or erase until the timer ends it
// RULE4: all data passes through one byte-wide table latch
// RULE5: table writes only load holding registers; array changes in timed cycle
// RULE6: table accesses are byte wide with no alignment needed
// RULE7: unlock register has no storage, only feeds start, reads zero
// RULE8: control bit 7 set selects program flash, clear selects data eeprom
// RULE9: control bit 6 set selects configuration space regardless of bit 7
// RULE10: erase enable bit 4 turns next start into row erase, cleared after
// RULE11: write enable bit 2 clear after reset; starts need it set
// RULE12: error bit 3 set at start, cleared when the timer completes
// RULE13: errors leave the memory and config select bits unchanged
// RULE14: start bit 1 set by software only, cleared by hardware at completion
// RULE15: read bit 0 gives one-cycle eeprom read, blocked for program/config
// RULE16: completion raises the write done interrupt flag set pulse
// RULE17: three byte registers form a 22-bit pointer; top bit reaches ids/config
// RULE18: four pointer updates, touching only the low 21 bits
// RULE19: a table read uses all 22 pointer bits
// RULE20: timed write block chosen by pointer bits 21 to 3
// RULE21: erase block chosen by pointer bits 21 to 6
// RULE22: software writes 55h then AAh to unlock before setting start
// RULE23: eight holding bytes reset to FFh and after each write; FFh keeps byte
// RULE24: each erase or write stalls the core about two milliseconds
// RULE25: start without enable or unlock changes nothing and does not stall; the code still sets error bit 3
module pfta_top #(
  parameter int unsigned PROG_CYCLES = `PFTA_PROG_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // special function register access
  input wire logic [2:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // table instructions
  input wire logic tbl_rd,
  input wire logic tbl_wt,
  input wire logic [1:0] tbl_mode,
  // flash array
  input wire logic [7:0] flash_rdata,
  output logic [21:0] flash_addr,
  output pfta_pkg::pfta_target_e flash_target,
  output logic flash_prog,
  output logic flash_erase,
  output logic [63:0] flash_block,
  output logic ee_rd,
  // core side status
  output logic stall,
  output logic write_done
);
  pfta_pkg::pfta_top_s q;
  pfta_pkg::pfta_top_s next_q;
  logic [21:0] acc;
  logic [21:0] ptr_upd;
  logic take_rd;
  logic take_wt;
  logic ctrl_wr;
  logic start_req;
  logic armed;
  logic finish;
  logic hold_we;
  logic hold_refill;
  logic [7:0] rd_mux;
  logic launch;

  // pointer arithmetic stays inside the low 21 bits
  function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic up);
    ptr_step = {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001}; // [RULE18]
  endfunction : ptr_step

  // a timed start owns its cycle; a table read there would replace the timed state and leave the stall stuck
  assign take_rd = tbl_rd && !launch && q.st == pfta_pkg::ST_IDLE;
  assign take_wt = tbl_wt && !tbl_rd && !launch && q.st == pfta_pkg::ST_IDLE;
  assign ctrl_wr = sfr_wr && sfr_sel == `PFTA_SEL_CTRL && q.st != pfta_pkg::ST_TIMED;
  assign start_req = ctrl_wr && sfr_wdata[`PFTA_B_WR] && !q.wr;
  // enable is taken from the written byte so one write may enable and start
  assign armed = q.unlock == 2'h2 && sfr_wdata[`PFTA_B_WRITE_ENABLE_BIT]; // [RULE22] [RULE11]
  assign launch = start_req && armed; // [RULE3]
  assign finish = q.st == pfta_pkg::ST_TIMED && q.tmr == 20'h00000;
  assign hold_we = take_wt; // [RULE5]
  assign hold_refill = finish && !q.free; // [RULE23]

  always_comb
  begin
    acc = (tbl_mode == `PFTA_PM_PREINC) ? ptr_step(q.ptr, 1'b1) : q.ptr; // [RULE18]
    unique case (tbl_mode)
      `PFTA_PM_KEEP: ptr_upd = q.ptr;
      `PFTA_PM_POSTINC: ptr_upd = ptr_step(q.ptr, 1'b1);
      `PFTA_PM_POSTDEC: ptr_upd = ptr_step(q.ptr, 1'b0);
      `PFTA_PM_PREINC: ptr_upd = acc;
    endcase
  end

  always_comb
  begin
    unique case (sfr_sel)
      `PFTA_SEL_CTRL: rd_mux = {q.pgd, q.cfg, 1'b0, q.free, q.err, q.write_enable_bit, q.wr, q.rd};
      `PFTA_SEL_LATCH: rd_mux = q.latch;
      `PFTA_SEL_PTRL: rd_mux = q.ptr[7:0];
      `PFTA_SEL_PTRH: rd_mux = q.ptr[15:8];
      `PFTA_SEL_PTRU: rd_mux = {2'h0, q.ptr[21:16]}; // [RULE17]
      default: rd_mux = 8'h00; // unlock key has no storage [RULE7]
    endcase
  end

  always_comb
  begin
    next_q = q;
    next_q.rdata = rd_mux;
    next_q.prog = 1'b0;
    next_q.erase = 1'b0;
    next_q.ee_rd = 1'b0;
    next_q.done = 1'b0;
    next_q.rd = 1'b0; // one-cycle read, hardware clears [RULE15]

    // plain register writes
    if (sfr_wr && q.st != pfta_pkg::ST_TIMED)
    begin
      unique case (sfr_sel)
        `PFTA_SEL_LATCH: next_q.latch = sfr_wdata; // [RULE4]
        `PFTA_SEL_PTRL: next_q.ptr[7:0] = sfr_wdata; // [RULE17]
        `PFTA_SEL_PTRH: next_q.ptr[15:8] = sfr_wdata; // [RULE17]
        `PFTA_SEL_PTRU: next_q.ptr[21:16] = sfr_wdata[5:0]; // [RULE17]
        `PFTA_SEL_KEY:
        begin
          // any wrong key restarts the sequence
          if (sfr_wdata == `PFTA_KEY1)
            next_q.unlock = 2'h1; // [RULE22]
          else if (sfr_wdata == `PFTA_KEY2 && q.unlock == 2'h1)
            next_q.unlock = 2'h2; // [RULE22]
          else
            next_q.unlock = 2'h0;
        end
        default:
        begin
        end
      endcase
    end

    if (ctrl_wr)
    begin
      next_q.pgd = sfr_wdata[`PFTA_B_PGD];
      next_q.cfg = sfr_wdata[`PFTA_B_CFG];
      next_q.free = sfr_wdata[`PFTA_B_FREE]; // [RULE10]
      next_q.write_enable_bit = sfr_wdata[`PFTA_B_WRITE_ENABLE_BIT]; // [RULE11]
      next_q.err = sfr_wdata[`PFTA_B_ERR];
      next_q.unlock = 2'h0; // key is consumed by any control write [RULE7]
      // read bit can only be set, and only for the data eeprom
      if (sfr_wdata[`PFTA_B_RD] && !sfr_wdata[`PFTA_B_PGD] && !sfr_wdata[`PFTA_B_CFG])
      begin
        next_q.rd = 1'b1; // [RULE15]
        next_q.ee_rd = 1'b1; // [RULE15]
      end
      if (start_req)
      begin
        // bad attempt flags an error but leaves array and core alone
        next_q.err = 1'b1; // [RULE12] [RULE25]
        if (armed)
        begin
          next_q.wr = 1'b1; // [RULE14]
          next_q.st = pfta_pkg::ST_TIMED; // [RULE3]
          next_q.stall = 1'b1; // [RULE3]
          next_q.tmr = 20'(PROG_CYCLES - 1); // [RULE24]
          if (sfr_wdata[`PFTA_B_FREE])
          begin
            next_q.erase = 1'b1; // [RULE2] [RULE10]
            next_q.faddr = {q.ptr[21:6], 6'h00}; // [RULE21]
          end
          else
          begin
            next_q.prog = 1'b1; // [RULE1] [RULE5]
            next_q.faddr = {q.ptr[21:3], 3'h0}; // [RULE20]
          end
        end
      end
    end

    // configuration select overrides memory select; read from the select
    // bits being written, so a start in the same write aims at its target
    if (next_q.cfg)
      next_q.tgt = pfta_pkg::TGT_CONFIG; // [RULE9]
    else if (next_q.pgd)
      next_q.tgt = pfta_pkg::TGT_PROGRAM; // [RULE8]
    else
      next_q.tgt = pfta_pkg::TGT_EEPROM; // [RULE8]

    unique case (q.st)
      pfta_pkg::ST_IDLE:
      begin
        if (take_rd)
        begin
          next_q.faddr = acc; // all 22 bits pick the byte [RULE19] [RULE6]
          next_q.ptr = ptr_upd; // [RULE18]
          next_q.st = pfta_pkg::ST_TREAD;
        end
        else if (take_wt)
          next_q.ptr = ptr_upd; // [RULE18] [RULE6]
      end
      pfta_pkg::ST_TREAD:
      begin
        next_q.latch = flash_rdata; // one byte per read [RULE1] [RULE4]
        next_q.st = pfta_pkg::ST_IDLE;
      end
      pfta_pkg::ST_TIMED:
      begin
        if (finish)
        begin
          next_q.st = pfta_pkg::ST_IDLE;
          next_q.stall = 1'b0; // [RULE3]
          next_q.wr = 1'b0; // [RULE14]
          next_q.free = 1'b0; // [RULE10]
          next_q.err = 1'b0; // [RULE12]
          next_q.done = 1'b1; // [RULE16]
        end
        else
          next_q.tmr = q.tmr - 20'h00001; // [RULE24]
      end
      default:
        next_q.st = pfta_pkg::ST_IDLE;
    endcase
  end

  // reset state: write enable off, pointer zero, error clear
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0; // [RULE11]
    end
    else
      q <= next_q;
  end

  pfta_holding u_hold (
    .mclk(mclk),
    .rstn(rstn),
    .we(hold_we),
    .idx(acc[2:0]),
    .wdata(q.latch),
    .refill(hold_refill),
    .block(flash_block)
  );

  assign sfr_rdata = q.rdata;
  assign flash_addr = q.faddr;
  assign flash_target = q.tgt;
  assign flash_prog = q.prog;
  assign flash_erase = q.erase;
  assign ee_rd = q.ee_rd;
  assign stall = q.stall;
  assign write_done = q.done;

  chk_stall_cause: assert property (@(posedge mclk) disable iff (!rstn) // [RULE3] [RULE14]
    $rose(stall) |-> $past(start_req) && $past(armed) && q.wr && q.err)
    else $error("stall without a proper start");
  chk_locked_start: assert property (@(posedge mclk) disable iff (!rstn) // [RULE25]
    start_req && !armed |=> !stall && !flash_prog && !flash_erase)
    else $error("start ran while locked");
  chk_finish_clears: assert property (@(posedge mclk) disable iff (!rstn) // [RULE12] [RULE16]
    $fell(stall) |-> write_done && !q.wr && !q.err && !q.free)
    else $error("completion left bits set");
  chk_key_zero: assert property (@(posedge mclk) disable iff (!rstn) // [RULE7]
    sfr_sel == `PFTA_SEL_KEY |=> sfr_rdata == 8'h00)
    else $error("unlock register read nonzero");
  chk_rd_pulse: assert property (@(posedge mclk) disable iff (!rstn) // [RULE15]
    q.rd |-> ee_rd ##1 !q.rd && !ee_rd)
    else $error("eeprom read not one cycle");
  chk_rd_blocked: assert property (@(posedge mclk) disable iff (!rstn) // [RULE15]
    ee_rd |-> !q.pgd && !q.cfg)
    else $error("eeprom read with program or config select");
  chk_ptr_top: assert property (@(posedge mclk) disable iff (!rstn) // [RULE18]
    (take_rd || take_wt) && !sfr_wr |=> q.ptr[21] == $past(q.ptr[21]))
    else $error("pointer update touched bit 21");
  chk_erase_block: assert property (@(posedge mclk) disable iff (!rstn) // [RULE21] [RULE2]
    flash_erase |-> flash_addr[5:0] == 6'h00 && stall)
    else $error("erase block misaligned");
  chk_prog_block: assert property (@(posedge mclk) disable iff (!rstn) // [RULE20] [RULE1]
    flash_prog |-> flash_addr[2:0] == 3'h0 && stall)
    else $error("write block misaligned");
  chk_sel_kept: assert property (@(posedge mclk) disable iff (!rstn) // [RULE13]
    stall |=> $stable(q.pgd) && $stable(q.cfg))
    else $error("select bits moved during cycle");
  chk_tread_latch: assert property (@(posedge mclk) disable iff (!rstn) // [RULE19] [RULE4]
    take_rd && !sfr_wr |-> ##1 (q.st == pfta_pkg::ST_TREAD) ##1 q.latch == $past(flash_rdata))
    else $error("table read did not load latch");
  chk_pulse_target: assert property (@(posedge mclk) disable iff (!rstn) // [RULE9] [RULE8]
    (flash_prog || flash_erase) |-> flash_target == (q.cfg ? pfta_pkg::TGT_CONFIG :
    (q.pgd ? pfta_pkg::TGT_PROGRAM : pfta_pkg::TGT_EEPROM)))
    else $error("timed cycle aimed at a stale target");
  chk_err_start: assert property (@(posedge mclk) disable iff (!rstn) // [RULE12]
    start_req |=> q.err)
    else $error("start attempt left error flag clear");
  chk_wr_held: assert property (@(posedge mclk) disable iff (!rstn) // [RULE14]
    q.wr && !finish |=> q.wr)
    else $error("start bit dropped before completion");
  chk_done_pulse: assert property (@(posedge mclk) disable iff (!rstn) // [RULE16]
    write_done |=> !write_done)
    else $error("completion pulse longer than one cycle");
endmodule : pfta_top

// ===== test/pfta_flash_model.sv
// Purpose: flash array behind the table access unit
// Assumes: program target backed by 256 bytes, other targets answer a pattern
// Notes: programming ands bytes in, so an all-ones byte keeps the cell
`timescale 1ns/10ps
module pfta_flash_model (
  // clock
  input wire logic mclk,
  // array port
  input wire logic [21:0] flash_addr,
  input wire pfta_pkg::pfta_target_e flash_target,
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic [63:0] flash_block,
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [256];
  logic is_prog;
  assign is_prog = flash_target == pfta_pkg::TGT_PROGRAM;
  // unbacked targets give an address pattern, never a stale byte
  assign flash_rdata = is_prog ? mem[flash_addr[7:0]] : flash_addr[7:0] ^ 8'h5A;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'hFF;
  end
  always @(posedge mclk)
  begin
    if (flash_prog && is_prog)
    begin
      for (int i = 0; i < 8; i++)
        mem[{flash_addr[7:3], i[2:0]}] &= flash_block[8*i +: 8];
    end
    if (flash_erase && is_prog)
    begin
      for (int i = 0; i < 64; i++)
        mem[{flash_addr[7:6], i[5:0]}] = 8'hFF;
    end
  end
endmodule : pfta_flash_model

// ===== test/tb_program_flash_table_access.sv
// Purpose: self-checking bench of the program flash table access unit
// Assumes: programming timer shortened to 20 cycles
// Notes: pulses are counted by a monitor, so checks do not hinge on one edge
`timescale 1ns/10ps
module tb_program_flash_table_access;
  localparam int PC = 20;
  localparam logic [21:0] PIN [4] = '{22'h000100, 22'h1FFFFF, 22'h200000, 22'h3FFFFF};
  localparam logic [21:0] POUT [4] = '{22'h000100, 22'h000000, 22'h3FFFFF, 22'h200000};
  logic mclk, rstn, sfr_wr, tbl_rd, tbl_wt, flash_prog, flash_erase, ee_rd, stall, write_done;
  logic [2:0] sfr_sel;
  logic [7:0] sfr_wdata, sfr_rdata, flash_rdata, v;
  logic [1:0] tbl_mode;
  logic [21:0] flash_addr, p, ev_addr;
  logic [63:0] flash_block, exp_blk;
  pfta_pkg::pfta_target_e flash_target, ev_tgt;
  int mismatches, check_count, cycles, n_prog, n_erase, n_ee, n_done, n_stall, s0, e0;
  pfta_top #(.PROG_CYCLES(PC)) i_dut (.mclk(mclk), .rstn(rstn), .sfr_sel(sfr_sel),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tbl_rd(tbl_rd),
    .tbl_wt(tbl_wt), .tbl_mode(tbl_mode), .flash_rdata(flash_rdata),
    .flash_addr(flash_addr), .flash_target(flash_target), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_block(flash_block), .ee_rd(ee_rd), .stall(stall),
    .write_done(write_done));
  pfta_flash_model i_flash (.mclk(mclk), .flash_addr(flash_addr),
    .flash_target(flash_target), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_block(flash_block), .flash_rdata(flash_rdata));
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    n_stall += int'(stall === 1'b1);
    n_prog += int'(flash_prog === 1'b1);
    n_erase += int'(flash_erase === 1'b1);
    n_ee += int'(ee_rd === 1'b1);
    n_done += int'(write_done === 1'b1);
    if (stall === 1'b1)
      ev_tgt = flash_target;
    if (flash_prog === 1'b1 || flash_erase === 1'b1)
      ev_addr = flash_addr;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    sfr_sel = s;
    sfr_wdata = d;
    sfr_wr = 1;
    step();
    sfr_wr = 0;
    step();
  endtask : wr
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    sfr_sel = s;
    step();
    d = sfr_rdata;
  endtask : rd
  task automatic setp(input logic [21:0] a);
    wr(3'h3, a[7:0]);
    wr(3'h4, a[15:8]);
    wr(3'h5, {2'h0, a[21:16]});
  endtask : setp
  task automatic getp(output logic [21:0] a);
    rd(3'h3, a[7:0]);
    rd(3'h4, a[15:8]);
    rd(3'h5, v);
    a[21:16] = v[5:0];
  endtask : getp
  task automatic tbl(input logic r, input logic [1:0] m);
    tbl_rd = r;
    tbl_wt = !r;
    tbl_mode = m;
    step();
    tbl_rd = 0;
    tbl_wt = 0;
    step();
    step();
  endtask : tbl
  // unlock keys straight before the start write, then wait for completion
  task automatic start(input logic [7:0] d);
    s0 = n_stall;
    wr(3'h1, 8'h55);
    wr(3'h1, 8'hAA);
    wr(3'h0, d);
    for (int k = 0; k < 100 && stall !== 1'b0; k++)
      step();
    step();
    chk("stall_cycles", n_stall - s0, PC);
  endtask : start
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    rstn = 0;
    sfr_sel = 0;
    sfr_wr = 0;
    sfr_wdata = 0;
    tbl_rd = 0;
    tbl_wt = 0;
    tbl_mode = 0;
    repeat (12) @(posedge mclk);
    #1 rstn = 1;
    step();
    rd(3'h0, v);
    chk("ctrl_reset", v, 8'h00);
    wr(3'h1, 8'h33);
    rd(3'h1, v);
    chk("key_read", v, 8'h00);
    wr(3'h5, 8'hFF);
    rd(3'h5, v);
    chk("ptr_upper", v, 8'h3F);
    for (int m = 0; m < 4; m++)
    begin
      setp(PIN[m]);
      tbl(1'b1, m[1:0]);
      getp(p);
      chk("ptr_update", p, POUT[m]);
    end
    $display("test pointer done");
    // unaligned fill wraps the holding index
    setp(22'h000013);
    for (int i = 0; i < 8; i++)
    begin
      wr(3'h2, 8'hA0 | i[7:0]);
      tbl(1'b0, 2'h1);
      exp_blk[8*((3+i)%8) +: 8] = 8'hA0 | i[7:0];
    end
    chk("holding", flash_block, exp_blk);
    chk("no_prog", n_prog, 0);
    rd(3'h2, v);
    chk("latch", v, 8'hA7);
    wr(3'h0, 8'hC6);
    step();
    rd(3'h0, v);
    chk("ctrl_locked_cfg", v, 8'hCC);
    wr(3'h0, 8'h86);
    step();
    rd(3'h0, v);
    chk("ctrl_locked", v, 8'h8C);
    chk("locked_stall", n_stall + n_prog, 0);
    $display("test holding done");
    start(8'h86);
    chk("prog_count", n_prog, 1);
    chk("prog_addr", ev_addr, 22'h000018);
    chk("prog_tgt", ev_tgt, pfta_pkg::TGT_PROGRAM);
    chk("done_count", n_done, 1);
    chk("refill", flash_block, {64{1'b1}});
    rd(3'h0, v);
    chk("ctrl_after_write", v, 8'h84);
    setp(22'h000017);
    for (int j = 0; j < 8; j++)
    begin
      tbl(1'b1, 2'h3);
      rd(3'h2, v);
      chk("readback", v, 8'hA0 | 8'((j + 5) % 8));
    end
    $display("test write done");
    setp(22'h000025);
    start(8'h96);
    chk("erase_count", n_erase, 1);
    chk("erase_addr", ev_addr, 22'h000000);
    chk("erase_no_prog", n_prog, 1);
    rd(3'h0, v);
    chk("ctrl_after_erase", v, 8'h84);
    setp(22'h000018);
    tbl(1'b1, 2'h0);
    rd(3'h2, v);
    chk("erased", v, 8'hFF);
    $display("test erase done");
    start(8'hC6);
    chk("cfg_tgt", ev_tgt, pfta_pkg::TGT_CONFIG);
    e0 = n_ee;
    wr(3'h0, 8'h01);
    step();
    step();
    chk("ee_read", n_ee - e0, 1);
    wr(3'h0, 8'h81);
    step();
    step();
    chk("ee_blocked", n_ee - e0, 1);
    rd(3'h0, v);
    chk("ctrl_rd", v, 8'h80);
    $display("test select done");
    tally_and_finish();
  end
endmodule : tb_program_flash_table_access
